// ### host_model.sv
// Host processor model that drives the byte-wide command and data port.
`timescale 1ns/10ps
`default_nettype none
module host_model
   import traj_pkg::*;
(
   // Clock and device status.
   input  wire logic       clk,
   input  wire logic       busy_q,
   // Port pins.
   output logic            cs_n,
   output logic            ps_n,
   output logic            wr_n,
   output logic [7:0]      db_in
);
   initial begin
      cs_n  = 1'b1;
      ps_n  = 1'b1;
      wr_n  = 1'b1;
      db_in = 8'h00;
   end

   // Deselected bus shows the inverse byte so a late sample cannot pass.
   task automatic put_byte(input logic ps, input logic [7:0] b);
      int n;
      n = 0;
      @(posedge clk);
      cs_n  <= 1'b0;
      wr_n  <= 1'b0;
      ps_n  <= ps;
      db_in <= b;
      repeat (3) @(posedge clk);
      cs_n  <= 1'b1;
      wr_n  <= 1'b1;
      db_in <= ~b;
      repeat (6) @(posedge clk);
      #1;
      while (busy_q !== 1'b0 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      repeat (2) @(posedge clk);
   endtask

   // Two short strobes back to back; the second lands while busy is high.
   task automatic rush_pair(input logic ps, input logic [7:0] b1,
                            input logic [7:0] b2);
      @(posedge clk);
      cs_n  <= 1'b0;
      wr_n  <= 1'b0;
      ps_n  <= ps;
      db_in <= b1;
      repeat (2) @(posedge clk);
      cs_n  <= 1'b1;
      wr_n  <= 1'b1;
      db_in <= ~b1;
      repeat (2) @(posedge clk);
      cs_n  <= 1'b0;
      wr_n  <= 1'b0;
      db_in <= b2;
      repeat (2) @(posedge clk);
      cs_n  <= 1'b1;
      wr_n  <= 1'b1;
      db_in <= ~b2;
      repeat (12) @(posedge clk);
   endtask

   task automatic send_cmd(input logic [7:0] c);
      put_byte(1'b0, c);
   endtask

   task automatic send_word(input logic [15:0] w);
      put_byte(1'b1, w[15:8]);
      put_byte(1'b1, w[7:0]);
   endtask

   task automatic send_param(input logic [31:0] p);
      send_word(p[31:16]);
      send_word(p[15:0]);
   endtask

   // Command, control word, then acceleration, velocity, position.
   task automatic load(input logic [15:0] cw, input logic [31:0] a,
                       input logic [31:0] v, input logic [31:0] p);
      send_cmd(LOAD_TRAJECTORY_CMD);
      send_word(cw);
      if (cw[CW_ACC_LD]) send_param(a);
      if (cw[CW_VEL_LD]) send_param(v);
      if (cw[CW_POS_LD]) send_param(p);
   endtask
endmodule // host_model
`default_nettype wire

// ### pin_sync.sv
// Two-stage synchroniser for the asynchronous host pins.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Raw pins and synchronised copy.
   input  wire logic [WIDTH-1:0] pins_async,
   output logic      [WIDTH-1:0] pins_sync
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               meta_q[i] <= 1'b1;
               sync_q[i] <= 1'b1;
            end else begin
               meta_q[i] <= pins_async[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   assign pins_sync = sync_q;
endmodule // pin_sync
`default_nettype wire

// ### tb_trajectory_load_and_start.sv
// Self-checking testbench of the trajectory load and start sequencer.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
   fails++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb_trajectory_load_and_start
   import traj_pkg::*;
;
   localparam logic [31:0] VEL = 32'h0001_2345;
   localparam logic [31:0] POS = 32'h0000_8000;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cs_n, ps_n, wr_n, busy_q;
   logic [7:0]  db_in;
   logic [31:0] work_accel_q, work_vel_q, work_pos_q;
   logic        velocity_mode_q, forward_q, track_actual_q;
   logic        motion_start_q, abrupt_stop_q, smooth_stop_q;
   logic [7:0]  run = 8'h00;
   logic [7:0]  last_run = 8'h00;
   logic        seen_abrupt = 1'b0;
   logic        seen_smooth = 1'b0;
   int          n_starts = 0;
   int          cycles = 0;
   int          fails = 0;
   int          n_compared = 0;

   always #50 clk = ~clk;

   trajectory_load_and_start dut (
      .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .ps_n(ps_n), .wr_n(wr_n),
      .db_in(db_in), .busy_q(busy_q), .work_accel_q(work_accel_q),
      .work_vel_q(work_vel_q), .work_pos_q(work_pos_q),
      .velocity_mode_q(velocity_mode_q), .forward_q(forward_q),
      .track_actual_q(track_actual_q), .motion_start_q(motion_start_q),
      .abrupt_stop_q(abrupt_stop_q), .smooth_stop_q(smooth_stop_q));

   host_model host (
      .clk(clk), .busy_q(busy_q), .cs_n(cs_n), .ps_n(ps_n), .wr_n(wr_n),
      .db_in(db_in));

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Busy run lengths, start pulses and the cycle ceiling.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (busy_q === 1'b1) run <= run + 8'h01;
      else if (run != 8'h00) begin
         last_run <= run;
         run      <= 8'h00;
      end
      if (motion_start_q === 1'b1) begin
         n_starts    <= n_starts + 1;
         seen_abrupt <= abrupt_stop_q;
         seen_smooth <= smooth_stop_q;
      end
      if (cycles == 8000) begin
         fails++;
         wrap_up();
      end
   end

   task automatic t_reset();
      `CHK("busy", 1'b0, busy_q)
      `CHK("accel", 32'h0, work_accel_q)
      `CHK("vel", 32'h0, work_vel_q)
      `CHK("pos", 32'h0, work_pos_q)
      `CHK("vmode", 1'b0, velocity_mode_q)
      `CHK("track", 1'b1, track_actual_q)
      $display("test reset done");
   endtask

   task automatic t_load_start();
      int k;
      host.load(16'h000a, 32'h0, VEL, POS);
      `CHK("busy run", 8'h04, last_run)
      `CHK("vel early", 32'h0, work_vel_q)
      `CHK("pos early", 32'h0, work_pos_q)
      `CHK("track early", 1'b1, track_actual_q)
      k = n_starts;
      host.send_cmd(START_MOTION_CMD);
      `CHK("starts", k + 1, n_starts)
      `CHK("vel", VEL, work_vel_q)
      `CHK("pos", POS, work_pos_q)
      `CHK("accel", 32'h0, work_accel_q)
      `CHK("vmode", 1'b0, velocity_mode_q)
      `CHK("track", 1'b0, track_actual_q)
      $display("test load_start done");
   endtask

   task automatic t_vel_rel();
      for (int i = 1; i <= 2; i++) begin
         host.load(16'h1830, 32'h50, 32'h0, 32'h0);
         host.send_cmd(START_MOTION_CMD);
         `CHK("accel rel", 32'(i * 32'h50), work_accel_q)
         `CHK("vel kept", VEL, work_vel_q)
         `CHK("vmode", 1'b1, velocity_mode_q)
         `CHK("forward", 1'b1, forward_q)
      end
      $display("test vel_rel done");
   endtask

   task automatic t_stray();
      int k;
      k = n_starts;
      host.put_byte(1'b1, START_MOTION_CMD);
      `CHK("data not cmd", k, n_starts)
      host.send_cmd(8'h33);
      host.send_cmd(START_MOTION_CMD);
      `CHK("starts", k + 1, n_starts)
      `CHK("accel kept", 32'ha0, work_accel_q)
      host.rush_pair(1'b0, START_MOTION_CMD, START_MOTION_CMD);
      `CHK("busy refusal", k + 2, n_starts)
      host.load(16'h000f, 32'h0, 32'h1, 32'h10);
      host.send_cmd(START_MOTION_CMD);
      `CHK("vel rel", VEL + 32'h1, work_vel_q)
      `CHK("pos rel", POS + 32'h10, work_pos_q)
      `CHK("vmode zero", 1'b0, velocity_mode_q)
      `CHK("forward", 1'b0, forward_q)
      $display("test stray done");
   endtask

   task automatic t_stops();
      for (int i = 0; i < 3; i++) begin
         host.load(16'h0100 << i, 32'h0, 32'h0, 32'h0);
         host.send_cmd(START_MOTION_CMD);
         `CHK("abrupt", (i == 1), seen_abrupt)
         `CHK("smooth", (i == 2), seen_smooth)
         `CHK("motor off", (i == 0), track_actual_q)
      end
      $display("test stops done");
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      t_reset();
      t_load_start();
      t_vel_rel();
      t_stray();
      t_stops();
      wrap_up();
   end
endmodule // tb_trajectory_load_and_start
`default_nettype wire

// ### traj_pkg.sv
// Constants, codes and state type of the trajectory load and start logic.
package traj_pkg;

   // Command codes written on the command port.
   localparam logic [7:0] LOAD_TRAJECTORY_CMD = 8'h1f;
   localparam logic [7:0] START_MOTION_CMD    = 8'h01;

   // Trajectory control word bit positions.
   localparam int CW_POS_REL   = 0;
   localparam int CW_POS_LD    = 1;
   localparam int CW_VEL_REL   = 2;
   localparam int CW_VEL_LD    = 3;
   localparam int CW_ACC_REL   = 4;
   localparam int CW_ACC_LD    = 5;
   localparam int CW_MOTOR_OFF = 8;
   localparam int CW_ABRUPT    = 9;
   localparam int CW_SMOOTH    = 10;
   localparam int CW_VEL_MODE  = 11;
   localparam int CW_FORWARD   = 12;

   // Parameter slots, in the order in which they arrive.
   localparam logic [1:0] SLOT_ACC = 2'h0;
   localparam logic [1:0] SLOT_VEL = 2'h1;
   localparam logic [1:0] SLOT_POS = 2'h2;
   localparam int NUM_PARAMS = 3;

   // Host-side pin vector layout after synchronisation.
   localparam int PIN_W    = 11;
   localparam int PIN_CS   = 10;
   localparam int PIN_PS   = 9;
   localparam int PIN_WR   = 8;

   // Busy time after a command byte or a completed data word.
   localparam int CLK_PERIOD_NS = 100;
   localparam int BUSY_TIME_NS  = 400;
   localparam int BUSY_CYCLES   =
      (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] BUSY_LOAD = 3'(BUSY_CYCLES);

   typedef enum logic [1:0] {
      S_IDLE    = 2'b00,
      S_CTRL_HI = 2'b01,
      S_CTRL_LO = 2'b10,
      S_PARAM   = 2'b11
   } seq_state_t;

endpackage

// ### trajectory_load_and_start.sv
// Trajectory load and start command sequencer with buffers and working set.
//
// Notes on behaviour
// - Load order is command, two-byte control word, then data words.
// - Load command starts capture into buffers kept apart from working set.
// - First two data bytes after load form the control word, high first.
// - Upper control byte holds mode, velocity direction and stopping flags.
// - Lower control byte flags which parameters follow and if relative.
// - Each chosen parameter is two words, so zero to six words.
// - Upper control byte of zero selects position mode.
// - Lower byte 0a expects four words, velocity and position, absolute.
// - Velocity words come before position words, high word first.
// - Position words follow velocity, high word first, each high byte first.
// - Start command applies buffers loaded since the last start to working set and starts motion.
// - Buffered parameters do not affect motion before a start.
// - Before the first start, desired position tracks measured position.
// - Control bits eight to ten pick stopping mode for the next start.
// - Bit eight motor off, nine abrupt stop, ten smooth stop.
// - All three parameters reset to zero until loaded.
`timescale 1ns/10ps
`default_nettype none
module trajectory_load_and_start
   import traj_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Host command/data port pins.
   input  wire logic        cs_n,
   input  wire logic        ps_n,
   input  wire logic        wr_n,
   input  wire logic [7:0]  db_in,
   // Host status.
   output logic             busy_q,
   // Working trajectory set.
   output logic [31:0]      work_accel_q,
   output logic [31:0]      work_vel_q,
   output logic [31:0]      work_pos_q,
   output logic             velocity_mode_q,
   output logic             forward_q,
   // Motion control actions.
   output logic             track_actual_q,
   output logic             motion_start_q,
   output logic             abrupt_stop_q,
   output logic             smooth_stop_q
);
   logic [PIN_W-1:0] pins_s;
   logic [PIN_W-1:0] prev_q;
   logic             wr_evt;
   logic             cmd_acc;
   logic             data_acc;
   logic [7:0]       wr_byte;

   pin_sync #(.WIDTH(PIN_W)) u_sync (
      .clk        (clk),
      .rst_n      (rst_n),
      .pins_async ({cs_n, ps_n, wr_n, db_in}),
      .pins_sync  (pins_s)
   );

   // A write is taken when the strobe ends, using the bytes seen during it.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev_q <= '1;
      end else begin
         prev_q <= pins_s;
      end
   end

   assign wr_evt   = !prev_q[PIN_CS] && !prev_q[PIN_WR] &&
                     !(!pins_s[PIN_CS] && !pins_s[PIN_WR]);
   assign wr_byte  = prev_q[7:0];
   assign cmd_acc  = wr_evt && !busy_q && !prev_q[PIN_PS];
   assign data_acc = wr_evt && !busy_q && prev_q[PIN_PS];

   seq_state_t  state_q, state_d;
   logic [2:0]  busy_cnt_q, busy_cnt_d;
   logic        busy_d;
   logic [15:0] ctrl_q, ctrl_d;
   logic [7:0]  hold_q, hold_d;
   logic        byte_lo_q, byte_lo_d;
   logic        word_lo_q, word_lo_d;
   logic [2:0]  rem_q, rem_d;
   logic [2:0]  fresh_q, fresh_d;
   logic [31:0] buf_q [NUM_PARAMS];
   logic [31:0] buf_d [NUM_PARAMS];
   logic [31:0] work_accel_d, work_vel_d, work_pos_d;
   logic        velocity_mode_d, forward_d, track_actual_d;
   logic        motion_start_d, abrupt_stop_d, smooth_stop_d;
   logic [1:0]  slot;
   logic        start_acc;

   // Parameters arrive in slot order: acceleration, velocity, position.
   always_comb begin
      if (rem_q[SLOT_ACC]) begin
         slot = SLOT_ACC;
      end else if (rem_q[SLOT_VEL]) begin
         slot = SLOT_VEL;
      end else begin
         slot = SLOT_POS;
      end
   end

   assign start_acc = cmd_acc && (wr_byte == START_MOTION_CMD);

   always_comb begin
      state_d         = state_q;
      busy_cnt_d      = (busy_cnt_q != 3'h0) ? busy_cnt_q - 3'h1 : 3'h0;
      ctrl_d          = ctrl_q;
      hold_d          = hold_q;
      byte_lo_d       = byte_lo_q;
      word_lo_d       = word_lo_q;
      rem_d           = rem_q;
      fresh_d         = fresh_q;
      buf_d           = buf_q;
      work_accel_d    = work_accel_q;
      work_vel_d      = work_vel_q;
      work_pos_d      = work_pos_q;
      velocity_mode_d = velocity_mode_q;
      forward_d       = forward_q;
      track_actual_d  = track_actual_q;
      motion_start_d  = 1'b0;
      abrupt_stop_d   = 1'b0;
      smooth_stop_d   = 1'b0;
      if (cmd_acc) begin
         busy_cnt_d = BUSY_LOAD;
         state_d    = S_IDLE;
         if (wr_byte == LOAD_TRAJECTORY_CMD) begin
            state_d = S_CTRL_HI;
         end
      end
      // Only parameters loaded since the last start are applied again.
      if (start_acc) begin
         if (fresh_q[SLOT_ACC]) begin
            work_accel_d = ctrl_q[CW_ACC_REL] ?
               work_accel_q + buf_q[SLOT_ACC] : buf_q[SLOT_ACC];
         end
         if (fresh_q[SLOT_VEL]) begin
            work_vel_d = ctrl_q[CW_VEL_REL] ?
               work_vel_q + buf_q[SLOT_VEL] : buf_q[SLOT_VEL];
         end
         if (fresh_q[SLOT_POS]) begin
            work_pos_d = ctrl_q[CW_POS_REL] ?
               work_pos_q + buf_q[SLOT_POS] : buf_q[SLOT_POS];
         end
         fresh_d         = 3'h0;
         velocity_mode_d = ctrl_q[CW_VEL_MODE];
         forward_d       = ctrl_q[CW_FORWARD];
         track_actual_d  = ctrl_q[CW_MOTOR_OFF];
         abrupt_stop_d   = ctrl_q[CW_ABRUPT];
         smooth_stop_d   = ctrl_q[CW_SMOOTH];
         motion_start_d  = 1'b1;
      end
      if (data_acc) begin
         case (state_q)
            S_CTRL_HI: begin
               ctrl_d[15:8] = wr_byte;
               state_d      = S_CTRL_LO;
            end
            S_CTRL_LO: begin
               ctrl_d[7:0] = wr_byte;
               busy_cnt_d  = BUSY_LOAD;
               rem_d       = {wr_byte[CW_POS_LD], wr_byte[CW_VEL_LD],
                              wr_byte[CW_ACC_LD]};
               byte_lo_d   = 1'b0;
               word_lo_d   = 1'b0;
               state_d     = (rem_d != 3'h0) ? S_PARAM : S_IDLE;
            end
            S_PARAM: begin
               if (!byte_lo_q) begin
                  hold_d    = wr_byte;
                  byte_lo_d = 1'b1;
               end else begin
                  byte_lo_d  = 1'b0;
                  busy_cnt_d = BUSY_LOAD;
                  if (!word_lo_q) begin
                     buf_d[slot][31:16] = {hold_q, wr_byte};
                     word_lo_d          = 1'b1;
                  end else begin
                     buf_d[slot][15:0] = {hold_q, wr_byte};
                     word_lo_d         = 1'b0;
                     rem_d[slot]       = 1'b0;
                     fresh_d[slot]     = 1'b1;
                     if (rem_d == 3'h0) begin
                        state_d = S_IDLE;
                     end
                  end
               end
            end
            default: begin
               state_d = state_q;
            end
         endcase
      end
      busy_d = (busy_cnt_d != 3'h0);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q         <= S_IDLE;
         busy_cnt_q      <= 3'h0;
         busy_q          <= 1'b0;
         ctrl_q          <= 16'h0000;
         hold_q          <= 8'h00;
         byte_lo_q       <= 1'b0;
         word_lo_q       <= 1'b0;
         rem_q           <= 3'h0;
         fresh_q         <= 3'h0;
         for (int i = 0; i < NUM_PARAMS; i++) begin
            buf_q[i] <= 32'h0000_0000;
         end
         work_accel_q    <= 32'h0000_0000;
         work_vel_q      <= 32'h0000_0000;
         work_pos_q      <= 32'h0000_0000;
         velocity_mode_q <= 1'b0;
         forward_q       <= 1'b0;
         track_actual_q  <= 1'b1;
         motion_start_q  <= 1'b0;
         abrupt_stop_q   <= 1'b0;
         smooth_stop_q   <= 1'b0;
      end else begin
         state_q         <= state_d;
         busy_cnt_q      <= busy_cnt_d;
         busy_q          <= busy_d;
         ctrl_q          <= ctrl_d;
         hold_q          <= hold_d;
         byte_lo_q       <= byte_lo_d;
         word_lo_q       <= word_lo_d;
         rem_q           <= rem_d;
         fresh_q         <= fresh_d;
         buf_q           <= buf_d;
         work_accel_q    <= work_accel_d;
         work_vel_q      <= work_vel_d;
         work_pos_q      <= work_pos_d;
         velocity_mode_q <= velocity_mode_d;
         forward_q       <= forward_d;
         track_actual_q  <= track_actual_d;
         motion_start_q  <= motion_start_d;
         abrupt_stop_q   <= abrupt_stop_d;
         smooth_stop_q   <= smooth_stop_d;
      end
   end

   // Checks on the sequencer.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_load_cmd;
      cmd_acc && wr_byte == LOAD_TRAJECTORY_CMD |=>
         state_q == S_CTRL_HI && busy_q;
   endproperty
   a_load_cmd: assert property (p_load_cmd)
      else $error("load command did not open the control word");

   property p_busy_word;
      data_acc && state_q == S_PARAM && byte_lo_q |=> busy_q [*4] ##1 !busy_q;
   endproperty
   a_busy_word: assert property (p_busy_word)
      else $error("busy not held four cycles after a data word");

   property p_ignore_busy;
      busy_q && wr_evt |=> $stable(state_q) && $stable(ctrl_q);
   endproperty
   a_ignore_busy: assert property (p_ignore_busy)
      else $error("write taken while busy");

   property p_ctrl_hi;
      data_acc && state_q == S_CTRL_HI |=>
         ctrl_q[15:8] == $past(wr_byte) && state_q == S_CTRL_LO;
   endproperty
   a_ctrl_hi: assert property (p_ctrl_hi)
      else $error("control word high byte not captured");

   property p_expect_four;
      data_acc && state_q == S_CTRL_LO && wr_byte == 8'h0a |=>
         state_q == S_PARAM && rem_q == 3'b110;
   endproperty
   a_expect_four: assert property (p_expect_four)
      else $error("0a control byte did not expect velocity and position");

   property p_no_words;
      data_acc && state_q == S_CTRL_LO && wr_byte == 8'h00 |=>
         state_q == S_IDLE;
   endproperty
   a_no_words: assert property (p_no_words)
      else $error("empty parameter set did not end the load");

   property p_buffer_only;
      !start_acc |=> $stable(work_pos_q) && $stable(work_vel_q) &&
         $stable(work_accel_q);
   endproperty
   a_buffer_only: assert property (p_buffer_only)
      else $error("working set changed without a start");

   property p_start_copy;
      start_acc && fresh_q[SLOT_POS] && !ctrl_q[CW_POS_REL] |=>
         work_pos_q == $past(buf_q[SLOT_POS]) && motion_start_q;
   endproperty
   a_start_copy: assert property (p_start_copy)
      else $error("start did not copy the buffered position");

   property p_motor_off;
      start_acc && ctrl_q[CW_MOTOR_OFF] |=> track_actual_q && !abrupt_stop_q;
   endproperty
   a_motor_off: assert property (p_motor_off)
      else $error("motor off start did not track actual position");

   property p_track_hold;
      track_actual_q && !start_acc |=> track_actual_q;
   endproperty
   a_track_hold: assert property (p_track_hold)
      else $error("tracking ended without a start");

   property p_reset_zero;
      $past(!rst_n) |-> work_pos_q == 32'h0000_0000 &&
         buf_q[SLOT_VEL] == 32'h0000_0000;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("parameters not zero after reset");

   c_four_words: cover property (rem_q == 3'b110 ##[1:300] state_q == S_IDLE);
   c_start: cover property (motion_start_q && !track_actual_q);
   c_abrupt: cover property (abrupt_stop_q);
   c_vel_mode: cover property (motion_start_q && velocity_mode_q);
endmodule // trajectory_load_and_start
`default_nettype wire
